// File: core/rnpc_pkg.sv
/*
 * constants shared by the reset / interrupt pin controller:
 * register offsets, control and status field positions, reset values
 * and the qualifying low time of the reset role.
 * assumes a 10 MHz system clock and a 32-bit apb register bus.
 */
package rnpc_pkg;

    // register byte offsets
    localparam logic [11:0] RNPC_CTRL_OFS = 12'h000;
    localparam logic [11:0] RNPC_STAT_OFS = 12'h004;

    // control register fields (reset_pin_control_reg)
    localparam int RNPC_ROLE_BIT = 0;   // pin_interrupt_role_select
    localparam int RNPC_EDGE_BIT = 1;   // pin_event_edge_select
    localparam int RNPC_IE_BIT = 2;     // pin_event_int_enable
    localparam int RNPC_PDIR_BIT = 3;   // pin_pull_direction
    localparam int RNPC_REN_BIT = 4;    // pin_resistor_enable
    localparam int RNPC_CTRL_W = 5;
    localparam logic [4:0] RNPC_CTRL_RST = 5'h18;  // reset role, pull-up on

    // status register fields
    localparam int RNPC_FLAG_BIT = 0;   // pin_event_flag, write 1 clears
    localparam int RNPC_PIN_BIT = 1;    // sampled pin level
    localparam int RNPC_DBG_BIT = 2;    // two-wire debug access active

    // clock and qualifying low time of the reset role
    localparam int RNPC_CLK_HZ = 10_000_000;
    localparam int RNPC_RST_MIN_NS = 2000;
    localparam int RNPC_RST_MIN_CYC =
        (RNPC_RST_MIN_NS * (RNPC_CLK_HZ / 1_000_000) + 999) / 1000;

    // reset-role qualifier states, gray from RNPC_IDLE to RNPC_WAIT_HIGH; the return to RNPC_IDLE flips both bits
    typedef enum logic [1:0] {
        RNPC_IDLE = 2'b00,
        RNPC_FIRE = 2'b01,
        RNPC_WAIT_HIGH = 2'b11
    } rnpc_state_e;

endpackage

// File: core/rnpc_pulse_timer.sv
/*
 * counts consecutive cycles of a run level and flags when the
 * programmed length has been reached.
 * assumes run is already synchronous to clk.
 */
`timescale 1ns/100ps
module rnpc_pulse_timer #(
    parameter int CNT_W = 8,
    parameter int CYCLES = 20
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    output logic done
);

    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;

    // saturate at the limit, restart whenever run drops
    always_comb begin
        if (!run) begin
            count_nxt = '0;
        end else if (count_r == LIMIT) begin
            count_nxt = count_r;
        end else begin
            count_nxt = count_r + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    // done in the cycle run has been high for CYCLES cycles
    assign done = run && (count_r == LIMIT);

endmodule

// File: core/rnpc_top.sv
/*
 * controller behind the shared reset / interrupt / debug-data pin.
 * assumes pin and apb inputs are synchronous to clk; the debug engine
 * outside drives dbg_active, dbg_tx_data and dbg_tx_en.
 */
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/100ps
module rnpc_top
    import rnpc_pkg::*;
#(
    parameter int RST_CYC = RNPC_RST_MIN_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic pull_up_en,
    output logic pull_down_en,
    input wire logic dbg_active,
    input wire logic dbg_tx_data,
    input wire logic dbg_tx_en,
    output logic two_wire_debug_data,
    output logic brownout_class_reset,
    output logic nmi_req
);

    ////////////////////////////////////////////////////////////////////
    // registers and next values

    logic [RNPC_CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic flag_r, flag_nxt;
    logic pin_prev_r, pin_prev_nxt;
    logic nmi_r, nmi_nxt;
    logic bor_r, bor_nxt;
    rnpc_state_e state_r, state_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic pin_out_r, pin_out_nxt;
    logic pin_oe_r, pin_oe_nxt;
    logic pu_r, pu_nxt;
    logic pd_r, pd_nxt;
    logic dbg_rx_r, dbg_rx_nxt;

    logic role_irq, edge_fall, irq_en;
    logic setup_ph, wr_access, ctrl_hit, stat_hit;
    logic rise, fall, edge_seen, low_run, low_done;

    assign role_irq = ctrl_r[RNPC_ROLE_BIT];
    assign edge_fall = ctrl_r[RNPC_EDGE_BIT];
    assign irq_en = ctrl_r[RNPC_IE_BIT];

    ////////////////////////////////////////////////////////////////////
    // apb decode: one wait-free access, pready raised from setup phase

    assign setup_ph = psel && !penable;
    assign wr_access = psel && penable && pready_r && pwrite;
    assign ctrl_hit = (paddr == RNPC_CTRL_OFS);
    assign stat_hit = (paddr == RNPC_STAT_OFS);

    // read data captured in setup so prdata is a flop in access
    always_comb begin
        prdata_nxt = prdata_r;
        pready_nxt = setup_ph;
        pslverr_nxt = setup_ph && !(ctrl_hit || stat_hit);
        if (setup_ph && !pwrite) begin
            prdata_nxt = '0;
            if (ctrl_hit) begin
                prdata_nxt[RNPC_CTRL_W-1:0] = ctrl_r;
            end else if (stat_hit) begin
                prdata_nxt[RNPC_FLAG_BIT] = flag_r;
                prdata_nxt[RNPC_PIN_BIT] = pin_prev_r;
                prdata_nxt[RNPC_DBG_BIT] = dbg_active;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reset-role qualifier: low must last RST_CYC cycles

    // debug data toggles the pin, so neither role listens then
    assign low_run = !role_irq && !dbg_active && !pin_in;

    rnpc_pulse_timer #(
        .CNT_W(16),
        .CYCLES(RST_CYC)
    ) u_low_timer (
        .clk(clk),
        .reset(reset),
        .run(low_run),
        .done(low_done)
    );

    // one brown-out pulse per qualifying low, re-armed on release
    always_comb begin
        state_nxt = state_r;
        bor_nxt = 1'b0;
        case (state_r)
            RNPC_IDLE: begin
                if (low_done) begin
                    state_nxt = RNPC_FIRE;
                    bor_nxt = 1'b1;
                end
            end
            RNPC_FIRE: begin
                state_nxt = RNPC_WAIT_HIGH;
            end
            RNPC_WAIT_HIGH: begin
                if (!low_run) begin
                    state_nxt = RNPC_IDLE;
                end
            end
            default: begin
                state_nxt = RNPC_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // control register; a brown-out returns it to its defaults

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (bor_r) begin
            ctrl_nxt = RNPC_CTRL_RST;
        end else if (wr_access && ctrl_hit) begin
            ctrl_nxt = pwdata[RNPC_CTRL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt role: edge detect, sticky flag, request

    assign rise = pin_in && !pin_prev_r;
    assign fall = !pin_in && pin_prev_r;
    assign edge_seen = role_irq && !dbg_active
        && (edge_fall ? fall : rise);

    // a new edge wins over a software clear in the same cycle
    always_comb begin
        pin_prev_nxt = pin_in;
        flag_nxt = flag_r;
        if (bor_r) begin
            flag_nxt = 1'b0;
        end else if (edge_seen) begin
            flag_nxt = 1'b1;
        end else if (wr_access && stat_hit && pwdata[RNPC_FLAG_BIT]) begin
            flag_nxt = 1'b0;
        end
        nmi_nxt = flag_nxt && ctrl_nxt[RNPC_IE_BIT];
    end

    ////////////////////////////////////////////////////////////////////
    // pad control: resistor and debug data line

    always_comb begin
        pu_nxt = ctrl_nxt[RNPC_REN_BIT] && ctrl_nxt[RNPC_PDIR_BIT];
        pd_nxt = ctrl_nxt[RNPC_REN_BIT] && !ctrl_nxt[RNPC_PDIR_BIT];
        pin_out_nxt = dbg_active && dbg_tx_data;
        pin_oe_nxt = dbg_active && dbg_tx_en;
        dbg_rx_nxt = dbg_active ? pin_in : 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // state registers

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_r <= RNPC_CTRL_RST;
            flag_r <= 1'b0;
            pin_prev_r <= 1'b1;
            nmi_r <= 1'b0;
            bor_r <= 1'b0;
            state_r <= RNPC_IDLE;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            pin_out_r <= 1'b0;
            pin_oe_r <= 1'b0;
            pu_r <= 1'b1;
            pd_r <= 1'b0;
            dbg_rx_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            flag_r <= flag_nxt;
            pin_prev_r <= pin_prev_nxt;
            nmi_r <= nmi_nxt;
            bor_r <= bor_nxt;
            state_r <= state_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            pu_r <= pu_nxt;
            pd_r <= pd_nxt;
            dbg_rx_r <= dbg_rx_nxt;
        end
    end

    // every output straight from a flop
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign pull_up_en = pu_r;
    assign pull_down_en = pd_r;
    assign two_wire_debug_data = dbg_rx_r;
    assign brownout_class_reset = bor_r;
    assign nmi_req = nmi_r;

    ////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_ROLE_DEFAULT: assert property (
        $rose(bor_r) |=> !ctrl_r[RNPC_ROLE_BIT])
        else $error("role not back to reset after brown-out");

    AST_BOR_QUAL: assert property (
        $rose(bor_r) |-> $past(low_run) && $past(low_run, 2))
        else $error("brown-out without a sustained low");

    AST_BOR_PULSE: assert property (
        bor_r |=> !bor_r)
        else $error("brown-out longer than one cycle");

    AST_NO_BOR_IRQ: assert property (
        role_irq && !bor_r |=> !bor_r)
        else $error("brown-out while in interrupt role");

    AST_EDGE_RISE: assert property (
        role_irq && !edge_fall && !dbg_active && !bor_r
        && !pin_prev_r && pin_in |=> flag_r)
        else $error("rising edge missed");

    AST_EDGE_FALL_ONLY: assert property (
        role_irq && edge_fall && !flag_r && !bor_r && !fall
        |=> !flag_r)
        else $error("flag set without a falling edge");

    AST_IRQ_NEEDS_EN: assert property (
        nmi_r |-> ctrl_r[RNPC_IE_BIT] && flag_r)
        else $error("request without enable and flag");

    AST_FLAG_SET: assert property (
        edge_seen && !bor_r |=> flag_r)
        else $error("edge did not set the flag");

    AST_FLAG_HOLD: assert property (
        flag_r && !bor_r && !(wr_access && stat_hit) |=> flag_r)
        else $error("flag dropped without a clear");

    AST_REQ_FOLLOWS: assert property (
        flag_r && ctrl_r[RNPC_IE_BIT] |-> nmi_r)
        else $error("request missing with flag and enable");

    AST_PULL_DIR: assert property (
        pu_r |-> !pd_r)
        else $error("both pulls on");

    AST_DBG_DRIVE: assert property (
        !dbg_active |=> !pin_oe_r)
        else $error("pin driven outside debug");

    AST_CTRL_DEFAULT: assert property (
        bor_r |=> ctrl_r == RNPC_CTRL_RST)
        else $error("control not back to defaults after brown-out");

    AST_PULL_OFF: assert property (
        !ctrl_r[RNPC_REN_BIT] |-> !pu_r && !pd_r)
        else $error("resistor on while disabled");

    // receive path is a one-cycle copy of the pad level while dbg_active, zero outside debug
    AST_DBG_RX: assert property (
        dbg_active |=> dbg_rx_r == $past(pin_in))
        else $error("debug data not taken from the pin");

    COV_BOR: cover property ($rose(bor_r));
    COV_NMI: cover property ($rose(nmi_r));
    COV_CLEAR_RACE: cover property (edge_seen && wr_access && stat_hit);
    COV_DBG: cover property (pin_oe_r && dbg_active);
    COV_FALL: cover property (edge_seen && edge_fall);

endmodule

// File: tb/rnpc_pin_model.sv
/*
 * far side of the shared pin: board driver or debug adapter plus the
 * pad resistor. assumes the enables come from the controller.
 */
`timescale 1ns/100ps
module rnpc_pin_model (
    input wire logic clk,
    input wire logic pin_oe,
    input wire logic pin_out,
    input wire logic pull_up_en,
    input wire logic pull_down_en,
    input wire logic ext_en,
    input wire logic ext_val,
    output logic pin_in
);
    logic float_r = 1'b0;

    ////////////////////////////////////////
    // a pad nobody holds wanders, never a stale level
    always @(posedge clk) begin
        float_r <= ~float_r;
    end

    // device drive first; adapter only drives a released pin
    always_comb begin
        if (pin_oe) pin_in = pin_out;
        else if (ext_en) pin_in = ext_val;
        else if (pull_up_en) pin_in = 1'b1;
        else if (pull_down_en) pin_in = 1'b0;
        else pin_in = float_r;
    end
endmodule

// File: tb/test_reset_nmi_pin_control.sv
/*
 * self-checking bench for the reset / interrupt pin controller.
 * assumes zero-wait apb and the pin model on the far side.
 */
`timescale 1ns/100ps
module test_reset_nmi_pin_control;
    import rnpc_pkg::*;
    localparam int RC = 3;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, pin_in, pin_out, pin_oe, pull_up_en;
    logic pull_down_en, two_wire_debug_data, brownout_class_reset;
    logic nmi_req, r;
    logic dbg_active = 0, dbg_tx_data = 0, dbg_tx_en = 0;
    logic ext_en = 1, ext_val = 1;
    logic [32:0] exp_q[$];
    logic [32:0] e_w;
    int num_errors = 0, n_tests = 0, bo_cnt = 0, cyc = 0;

    rnpc_top #(.RST_CYC(RC)) u_dut (.clk, .reset, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in,
        .pin_out, .pin_oe, .pull_up_en, .pull_down_en, .dbg_active,
        .dbg_tx_data, .dbg_tx_en, .two_wire_debug_data,
        .brownout_class_reset, .nmi_req);
    rnpc_pin_model u_pin (.clk, .pin_oe, .pin_out, .pull_up_en,
        .pull_down_en, .ext_en, .ext_val, .pin_in);

    ////////////////////////////////////////
    initial begin
        forever #50 clk = ~clk;
    end

    task automatic check(string nm, logic [32:0] seen, logic [32:0] e);
        n_tests++;
        if (seen !== e) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, e, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one transfer; psel drops a cycle between calls
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d,
                       logic [32:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // pready ends this wait; the bench timeout is the only guard
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask

    // drive the pin low for n samples, then idle high
    task automatic low(int n);
        ext_val <= 0;
        repeat (n) @(posedge clk);
        ext_val <= 1;
        repeat (4) @(posedge clk);
    endtask

    ////////////////////////////////////////
    // watcher: read data against queued notes, pulse count, timeout
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            num_errors++;
            test_done();
        end
        if (brownout_class_reset === 1'b1) bo_cnt++;
        if (psel && penable && pready === 1'b1) begin
            e_w = exp_q.pop_front();
            if (pwrite)
                check("write err", pslverr, e_w[32]);
            else
                check("read", {pslverr, prdata}, e_w);
        end
    end

    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h538a4f2a));
        repeat (3) @(posedge clk);
        reset <= 0;
        check("pulls", {pull_up_en, pull_down_en}, 2'b10);
        apb(0, RNPC_CTRL_OFS, 0, 33'h18);
        apb(0, RNPC_STAT_OFS, 0, 33'h2);
        apb(1, 12'h008, 32'h1f, {1'b1, 32'h0});
        apb(0, 12'h008, 0, {1'b1, 32'h0});
        apb(0, RNPC_CTRL_OFS, 0, 33'h18);
        $display("registers done");
        low(RC - 1);
        check("short low", 33'(bo_cnt), 0);
        low(8);
        check("long low", 33'(bo_cnt), 1);
        low(RC);
        check("edge low", 33'(bo_cnt), 2);
        $display("reset role done");
        apb(1, RNPC_CTRL_OFS, 32'h19, 0);
        low(2);
        check("nmi off", nmi_req, 0);
        apb(0, RNPC_STAT_OFS, 0, 33'h3);
        check("no bor", 33'(bo_cnt), 2);
        apb(1, RNPC_CTRL_OFS, 32'h1d, 0);
        @(posedge clk);
        check("nmi on", nmi_req, 1);
        apb(1, RNPC_STAT_OFS, 32'h1, 0);
        @(posedge clk);
        check("nmi clr", nmi_req, 0);
        apb(1, RNPC_CTRL_OFS, 32'h1f, 0);
        low(8);
        check("fall", nmi_req, 1);
        check("no bor", 33'(bo_cnt), 2);
        ext_val <= 0;
        repeat (3) @(posedge clk);
        apb(1, RNPC_STAT_OFS, 32'h1, 0);
        ext_val <= 1;
        repeat (3) @(posedge clk);
        apb(0, RNPC_STAT_OFS, 0, 33'h2);
        $display("interrupt role done");
        ext_en <= 0;
        apb(1, RNPC_CTRL_OFS, 32'h11, 0);
        repeat (3) @(posedge clk);
        check("pull dn", {pull_up_en, pull_down_en}, 2'b01);
        apb(0, RNPC_STAT_OFS, 0, 33'h0);
        apb(1, RNPC_CTRL_OFS, 32'h01, 0);
        repeat (3) @(posedge clk);
        check("pull off", {pull_up_en, pull_down_en}, 2'b00);
        ext_en <= 1;
        apb(1, RNPC_CTRL_OFS, 32'h18, 0);
        $display("resistor done");
        dbg_active <= 1;
        dbg_tx_en <= 1;
        ext_en <= 0;
        repeat (8) begin
            r = 1'($urandom);
            dbg_tx_data <= r;
            repeat (3) @(posedge clk);
            check("tx", {pin_oe, pin_out, two_wire_debug_data},
                  {1'b1, r, r});
        end
        dbg_tx_en <= 0;
        ext_en <= 1;
        repeat (8) begin
            r = 1'($urandom);
            ext_val <= r;
            repeat (3) @(posedge clk);
            check("rx", {pin_oe, two_wire_debug_data}, {1'b0, r});
        end
        check("dbg bor", 33'(bo_cnt), 2);
        $display("debug done");
        test_done();
    end
endmodule
